// *** include/crp_defs.svh ***
// timing, width and reset constants for the clocked response port
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH
`define CRP_CLK_MHZ 200
`define CRP_REF_MHZ 100
`define CRP_REF_DIV (`CRP_CLK_MHZ / `CRP_REF_MHZ)
`define CRP_NUM_CLKBLK 6
`define CRP_SEL_W 3
`define CRP_DIV_W 8
`define CRP_CNT_W 16
`define CRP_XFER_W 32
`define CRP_SLICE_W 6
`define CRP_PORT_W 4
`define CRP_CLK_SEL_RST 3'h0
`endif

// *** include/crp_pkg.sv ***
// types shared by the clocked response port modules
`include "crp_defs.svh"
package crp_pkg;
  // core command codes, one-hot
  typedef enum logic [3:0] {
    CRP_OP_NONE = 4'b0001,
    CRP_OP_OUT = 4'b0010,
    CRP_OP_IN = 4'b0100,
    CRP_OP_SETCLK = 4'b1000
  } crp_op_t;
  // input start condition, one-hot
  typedef enum logic [2:0] {
    CRP_COND_NONE = 3'b001,
    CRP_COND_EQ = 3'b010,
    CRP_COND_NEQ = 3'b100
  } crp_cond_t;
  // clock block state
  typedef struct packed {
    logic [`CRP_DIV_W-1:0] cnt;
    logic tick;
  } crp_clkblk_st_t;
  // port state
  typedef struct packed {
    logic pd;
    logic ext_q;
    logic [`CRP_SEL_W-1:0] clk_sel;
    logic [`CRP_CNT_W-1:0] cnt;
    logic [`CRP_XFER_W-1:0] tr;
    logic tr_full;
    logic [`CRP_XFER_W-1:0] sh;
    logic [`CRP_SLICE_W-1:0] sh_cnt;
    logic timed;
    logic [`CRP_CNT_W-1:0] time_val;
    logic [`CRP_CNT_W-1:0] tstamp;
    logic [`CRP_XFER_W-1:0] pin_q;
    logic stb_out;
    logic [`CRP_XFER_W-1:0] rd_data;
    logic rd_valid;
    logic event_q;
  } crp_port_st_t;
endpackage

// *** include/crp_clk_if.sv ***
// link between the port and one clock block
`timescale 1ns/100ps
`default_nettype none
`include "crp_defs.svh"
interface crp_clk_if;
  logic src_tick; // source edge enable
  logic [`CRP_DIV_W-1:0] div; // divide setting, n means n+1
  logic tick; // divided port clock enable
  modport blk(input src_tick, input div, output tick);
  modport user(output src_tick, output div, input tick);
endinterface
`default_nettype wire

// *** logic/crp_clkblk.sv ***
// clock block: divides a source enable into a port clock enable
`timescale 1ns/100ps
`default_nettype none
`include "crp_defs.svh"
module crp_clkblk
  import crp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  crp_clk_if.blk cb
);
  crp_clkblk_st_t s; // registered state
  crp_clkblk_st_t next_s; // next state

  // count source edges, pulse on wrap
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (cb.src_tick) begin
      if (s.cnt >= cb.div) begin
        next_s.cnt = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cb.tick = s.tick;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_CB_TICK: assert property (s.tick |-> $past(cb.src_tick)) // RL15
    else $error("clock block ticked without a source edge");
endmodule
`default_nettype wire

// *** logic/crp_port.sv ***
// programmable pin port with serializer, counter and six clock blocks
// Summary of operation
// RL1: one direction for all pins of port
// RL2: port width 1, 4, 8, 16 or 32
// RL3: drive pins or sample, optional start condition
// RL4: accepted port command completes in one cycle
// RL5: open collector drives zero, floats one
// RL6: data passes serializer and transfer register
// RL7: each port has a 16-bit counter
// RL8: counter readable; transfers wait for time
// RL9: counter captured as timestamp on transfer
// RL10: enabled link disconnects shared port pins
// RL11: narrower enabled port takes shared pins
// RL12: unshared pins remain with wider port
// RL13: words always keep the nominal width
// RL14: six clock blocks, block 0 at 100MHz
// RL15: clock block may use divided external clock
// RL16: strobes qualify input and accompany output
// RL17: after reset port uses clock block 0
// RL18: pin conditions raise events to scheduler
// RL19: pull-downs enabled while held in reset
// RL20: external sampling clock at most 60 MHz
// RL21: counter steps per port tick, wraps
// RL22: timed transfer on first matching tick
`timescale 1ns/100ps
`default_nettype none
`include "crp_defs.svh"
module crp_port
  import crp_pkg::*;
#(
  parameter int PW = `CRP_PORT_W, // RL2
  parameter int NCB = `CRP_NUM_CLKBLK
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  input wire crp_op_t CMD_OP,
  input wire logic [`CRP_XFER_W-1:0] CMD_DATA,
  input wire logic CMD_TIMED,
  input wire logic [`CRP_CNT_W-1:0] CMD_TIME,
  output logic CMD_READY,
  output logic RD_VALID,
  output logic [`CRP_XFER_W-1:0] RD_DATA,
  input wire logic CFG_DIR_OUT,
  input wire logic CFG_OPEN_COLLECTOR,
  input wire crp_cond_t CFG_COND,
  input wire logic [PW-1:0] CFG_COND_VAL,
  input wire logic CFG_STROBE_IN_EN,
  input wire logic [NCB*`CRP_DIV_W-1:0] CLKBLK_DIV,
  input wire logic [NCB-1:0] CLKBLK_EXT_SRC,
  input wire logic EXT_CLK_PIN,
  input wire logic LINK_EN,
  input wire logic [PW-1:0] NARROW_OWN,
  input wire logic [PW-1:0] PIN_IN,
  output logic [PW-1:0] PIN_OUT,
  output logic [PW-1:0] PIN_OE,
  output logic PIN_PULLDN,
  input wire logic STROBE_FROM_EXTERNAL,
  output logic STROBE_TO_EXTERNAL,
  output logic [`CRP_CNT_W-1:0] PORT_COUNT,
  output logic [`CRP_CNT_W-1:0] TIMESTAMP,
  output logic EVENT
);
  // slices per transfer word, less one
  localparam logic [`CRP_SLICE_W-1:0] SLICES_M1 = `CRP_SLICE_W'(`CRP_XFER_W / PW - 1);
  // reset value: pull-downs on, clock block 0
  localparam crp_port_st_t ST_RST = '{pd: 1'b1, clk_sel: `CRP_CLK_SEL_RST, default: '0};

  crp_port_st_t s; // registered state
  crp_port_st_t next_s; // next state
  logic [NCB-1:0] ticks; // enables from all clock blocks
  logic tick; // selected port clock enable
  logic ext_rise; // rising edge on external clock pin
  logic [PW-1:0] own; // pins this port may use
  logic [PW-1:0] pins; // owned input pins
  logic [`CRP_XFER_W-1:0] pins32; // input pins widened
  logic cond_ok; // start condition met
  logic qual; // input sample qualified by strobe
  logic cmd_take; // command accepted this cycle
  logic xfer_now; // word moves at the transfer register

  // link takes all pins, narrower ports take theirs
  assign own = ~NARROW_OWN & {PW{~LINK_EN}}; // RL10 RL11 RL12
  assign pins = PIN_IN & own; // RL13
  assign pins32 = `CRP_XFER_W'(pins);
  assign ext_rise = EXT_CLK_PIN & ~s.ext_q;

  // clock blocks: block 0 from reference, others programmable
  genvar gi;
  generate
    for (gi = 0; gi < NCB; gi++) begin : g_cb
      crp_clk_if cbi ();
      if (gi == 0) begin : g_ref
        assign cbi.src_tick = 1'b1; // RL14
        assign cbi.div = `CRP_DIV_W'(`CRP_REF_DIV - 1); // RL14
      end else begin : g_prog
        assign cbi.src_tick = CLKBLK_EXT_SRC[gi] ? ext_rise : 1'b1; // RL15
        assign cbi.div = CLKBLK_DIV[gi*`CRP_DIV_W +: `CRP_DIV_W]; // RL14 RL15
      end
      crp_clkblk u_cb (
        .clk(CLK),
        .reset(RESET),
        .cb(cbi.blk)
      );
      assign ticks[gi] = cbi.tick;
    end
  endgenerate

  // port clock from the selected block
  assign tick = (32'(s.clk_sel) < NCB) ? ticks[s.clk_sel] : 1'b0; // RL17

  // start condition on the pin value
  always_comb begin
    case (CFG_COND)
      CRP_COND_EQ: cond_ok = (pins == (CFG_COND_VAL & own)); // RL3
      CRP_COND_NEQ: cond_ok = (pins != (CFG_COND_VAL & own)); // RL3
      default: cond_ok = 1'b1;
    endcase
  end

  // incoming strobe gates sampling when enabled
  assign qual = ~CFG_STROBE_IN_EN | STROBE_FROM_EXTERNAL; // RL16

  // out needs a free transfer register, in needs a full one
  always_comb begin
    case (CMD_OP)
      CRP_OP_OUT: CMD_READY = ~s.tr_full;
      CRP_OP_IN: CMD_READY = s.tr_full;
      default: CMD_READY = 1'b1;
    endcase
  end
  assign cmd_take = CMD_VALID & CMD_READY; // RL4

  // next state of the whole port
  always_comb begin
    next_s = s;
    xfer_now = 1'b0;
    next_s.pd = 1'b0; // RL19
    next_s.ext_q = EXT_CLK_PIN;
    next_s.rd_valid = 1'b0;
    next_s.event_q = 1'b0;
    // core command, done in this cycle
    if (cmd_take) begin
      case (CMD_OP)
        CRP_OP_OUT: begin
          next_s.tr = CMD_DATA; // RL6
          next_s.tr_full = 1'b1;
          next_s.timed = CMD_TIMED; // RL8
          next_s.time_val = CMD_TIME;
        end
        CRP_OP_IN: begin
          next_s.rd_data = s.tr; // RL4
          next_s.rd_valid = 1'b1;
          next_s.tr_full = 1'b0;
          next_s.timed = CMD_TIMED; // RL8
          next_s.time_val = CMD_TIME;
        end
        CRP_OP_SETCLK: begin
          next_s.clk_sel = CMD_DATA[`CRP_SEL_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // port clock edge
    if (tick) begin
      next_s.cnt = s.cnt + 16'h0001; // RL7 RL21
      if (CFG_DIR_OUT) begin
        if (s.sh_cnt != '0) begin
          // next slice of the word being sent
          next_s.pin_q = '0;
          next_s.pin_q[PW-1:0] = s.sh[PW-1:0]; // RL6
          next_s.sh = s.sh >> PW;
          next_s.sh_cnt = s.sh_cnt - 6'h01;
          next_s.stb_out = 1'b1; // RL16
        end else if (s.tr_full && (!s.timed || s.cnt == s.time_val)) begin
          // word leaves the transfer register
          xfer_now = 1'b1;
          next_s.pin_q = '0;
          next_s.pin_q[PW-1:0] = s.tr[PW-1:0]; // RL22
          next_s.sh = s.tr >> PW;
          next_s.sh_cnt = SLICES_M1; // RL13
          next_s.tr_full = 1'b0;
          next_s.timed = 1'b0;
          next_s.tstamp = s.cnt; // RL9
          next_s.event_q = 1'b1; // RL18
          next_s.stb_out = 1'b1; // RL16
        end else begin
          next_s.stb_out = 1'b0; // pins keep last value
        end
      end else begin
        next_s.stb_out = 1'b0;
        // start a word only on condition and time
        if (!s.tr_full && qual &&
            (s.sh_cnt != '0 ||
             (cond_ok && (!s.timed || s.cnt == s.time_val)))) begin // RL3 RL22
          next_s.sh = (s.sh >> PW) | (pins32 << (`CRP_XFER_W - PW)); // RL6
          if (s.sh_cnt == SLICES_M1) begin
            // full word into the transfer register
            xfer_now = 1'b1;
            next_s.tr = (s.sh >> PW) | (pins32 << (`CRP_XFER_W - PW)); // RL13
            next_s.tr_full = 1'b1;
            next_s.sh_cnt = '0;
            next_s.timed = 1'b0;
            next_s.tstamp = s.cnt; // RL9
            next_s.event_q = 1'b1; // RL18
          end else begin
            next_s.sh_cnt = s.sh_cnt + 6'h01;
            // time was met at the first slice, later slices need strobe only
            next_s.timed = 1'b0; // RL22
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // pin drive: direction, ownership, open collector, reset
  always_comb begin
    if (CFG_OPEN_COLLECTOR) begin
      PIN_OUT = '0; // RL5
      PIN_OE = own & ~s.pin_q[PW-1:0] & {PW{CFG_DIR_OUT & ~s.pd}}; // RL5 RL1
    end else begin
      PIN_OUT = s.pin_q[PW-1:0];
      PIN_OE = own & {PW{CFG_DIR_OUT & ~s.pd}}; // RL1 RL12
    end
  end

  // registered outputs
  assign PIN_PULLDN = s.pd; // RL19
  assign STROBE_TO_EXTERNAL = s.stb_out;
  assign PORT_COUNT = s.cnt; // RL8
  assign TIMESTAMP = s.tstamp;
  assign RD_VALID = s.rd_valid;
  assign RD_DATA = s.rd_data;
  assign EVENT = s.event_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_WIDTH: assert property (PW == 1 || PW == 4 || PW == 8 || PW == 16 || PW == 32) // RL2
    else $error("port width not one of the offered widths");
  AST_DIR_IN: assert property (!CFG_DIR_OUT |-> PIN_OE == '0) // RL1
    else $error("input port drives its pins");
  AST_OC: assert property (CFG_OPEN_COLLECTOR |-> PIN_OUT == '0
      && (own & ~s.pin_q[PW-1:0] & ~PIN_OE & {PW{CFG_DIR_OUT && !s.pd}}) == '0
      && (PIN_OE & s.pin_q[PW-1:0]) == '0) // RL5
    else $error("open collector drives a one");
  AST_LINK: assert property (LINK_EN |-> PIN_OE == '0) // RL10
    else $error("port drives pins owned by the link");
  AST_NARROW: assert property ((PIN_OE & NARROW_OWN) == '0) // RL11
    else $error("wide port drives pins of a narrower port");
  AST_WIDE: assert property (CFG_DIR_OUT && !LINK_EN && !CFG_OPEN_COLLECTOR && !s.pd
      |-> PIN_OE == ~NARROW_OWN) // RL12
    else $error("unshared pins lost by the wide port");
  AST_CNT: assert property (tick |=> PORT_COUNT == $past(PORT_COUNT) + 16'h0001) // RL21
    else $error("counter did not step on port tick");
  AST_CNT_HOLD: assert property (!tick |=> $stable(PORT_COUNT)) // RL7
    else $error("counter moved without a port tick");
  AST_TSTAMP: assert property (xfer_now |=> TIMESTAMP == $past(PORT_COUNT) && EVENT) // RL9
    else $error("timestamp or event missing on transfer");
  AST_TIMED: assert property (xfer_now && s.timed |-> s.cnt == s.time_val) // RL22
    else $error("timed transfer on wrong count");
  AST_RD: assert property (cmd_take && CMD_OP == CRP_OP_IN |=> RD_VALID
      && RD_DATA == $past(s.tr)) // RL4
    else $error("read did not complete in one cycle");
  AST_STROBE: assert property (tick && CFG_DIR_OUT && s.sh_cnt != '0
      |=> STROBE_TO_EXTERNAL) // RL16
    else $error("output slice without strobe");

  COV_OUT: cover property (xfer_now && CFG_DIR_OUT);
  COV_IN: cover property (xfer_now && !CFG_DIR_OUT);
  COV_TIMED: cover property (xfer_now && s.timed);
  COV_EXT: cover property (ext_rise && s.clk_sel != '0);
endmodule
`default_nettype wire

// *** verification/crp_ext_model.sv ***
// external hardware model: presents strobed input slices, records output slices
`timescale 1ns/100ps
`default_nettype none
module crp_ext_model #(
  parameter int PW = 4
) (
  input wire logic clk,
  input wire logic [PW-1:0] pin_out,
  input wire logic [PW-1:0] pin_oe,
  input wire logic pin_pulldn,
  input wire logic oc,
  input wire logic strobe_to_external,
  output logic [PW-1:0] pin_in,
  output logic strobe_from_external
);
  logic drv = 1'b0; // model drives the pins
  logic [PW-1:0] dat = '0; // slice on the pins
  logic [PW-1:0] junk = '0; // floating level, changes every cycle
  logic [PW-1:0] seen [$]; // pin values seen while strobed
  logic [PW-1:0] oe_seen [$]; // enables seen while strobed
  initial strobe_from_external = 1'b0;
  // wire level from all drivers
  always_comb begin
    for (int i = 0; i < PW; i++) begin
      if (pin_oe[i]) pin_in[i] = oc ? 1'b0 : pin_out[i];
      else if (drv) pin_in[i] = dat[i];
      else pin_in[i] = pin_pulldn ? 1'b0 : junk[i];
    end
  end
  // floating pins never hold a stale value
  always @(posedge clk) junk <= ~junk;
  // record driven slices, a float reads as one in open collector
  always @(negedge clk) begin
    if (strobe_to_external) begin
      seen.push_back(oc ? ~pin_oe : pin_out);
      oe_seen.push_back(pin_oe);
    end
  end
  // one slice per two-cycle strobe window, so exactly one port tick sees it
  task automatic send_word(input logic [31:0] w);
    for (int k = 0; k < 32 / PW; k++) begin
      @(posedge clk);
      drv <= 1'b1;
      dat <= w[k*PW+:PW];
      strobe_from_external <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      strobe_from_external <= 1'b0;
      @(posedge clk);
    end
    drv <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the clocked response port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import crp_pkg::*;
  // port starts as output, so no stray input word fills the transfer register
  logic clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_timed = 1'b0, dir_out = 1'b1;
  logic oc = 1'b0, stb_en = 1'b0, link = 1'b0;
  crp_cond_t cond = CRP_COND_NONE;
  logic [3:0] cond_val = 4'h0;
  logic [47:0] cb_div = 48'h0;
  logic [5:0] ext_src = 6'h02; // block 1 counts external edges from reset on
  logic [1:0] ext_ph = 2'h0; // external clock phase
  logic ext_run = 1'b0; // external clock running
  logic [7:0] d;
  crp_op_t cmd_op = CRP_OP_NONE;
  logic [31:0] cmd_data = '0, rd_data, w, w2, e;
  logic [15:0] cmd_time = '0, port_count, timestamp, c0;
  logic [3:0] own = '0, pin_in, pin_out, pin_oe, m;
  logic cmd_ready, rd_valid, pin_pulldn, stb_in, stb_out, evt;
  int n_fail = 0, checks_done = 0, n_evt = 0, n_xfer = 0, cycles = 0;
  int seed = 32'ha6fe4c8b;
  // output configs: open collector, narrower owner, link
  logic oc_t [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [3:0] own_t [4] = '{4'h0, 4'h0, 4'h3, 4'h0};
  logic link_t [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  always #2.5 clk = ~clk;
  // external port clock, 4 CLK period (50 MHz), still while not in use
  always @(posedge clk) if (ext_run) ext_ph <= ext_ph + 2'h1;
  crp_port #(.PW(4), .NCB(6)) i_dut (.CLK(clk), .RESET(reset), .CMD_VALID(cmd_valid),
    .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_TIMED(cmd_timed), .CMD_TIME(cmd_time),
    .CMD_READY(cmd_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data), .CFG_DIR_OUT(dir_out),
    .CFG_OPEN_COLLECTOR(oc), .CFG_COND(cond), .CFG_COND_VAL(cond_val),
    .CFG_STROBE_IN_EN(stb_en), .CLKBLK_DIV(cb_div), .CLKBLK_EXT_SRC(ext_src),
    .EXT_CLK_PIN(ext_ph[1]), .LINK_EN(link), .NARROW_OWN(own), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLDN(pin_pulldn),
    .STROBE_FROM_EXTERNAL(stb_in), .STROBE_TO_EXTERNAL(stb_out), .PORT_COUNT(port_count),
    .TIMESTAMP(timestamp), .EVENT(evt));
  crp_ext_model #(.PW(4)) i_ext (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pulldn(pin_pulldn), .oc(oc), .strobe_to_external(stb_out), .pin_in(pin_in),
    .strobe_from_external(stb_in));
  // compare and count
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // core command, held until taken
  task automatic cmd(input crp_op_t op, input logic [31:0] d, input logic [15:0] t);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_timed <= (op == CRP_OP_OUT);
    cmd_time <= t;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // transfer events seen by the scheduler side
  always @(negedge clk) if (evt === 1'b1) n_evt++;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    chk("oe_reset", pin_oe, 0);
    chk("pulldn_reset", pin_pulldn, 1);
    chk("count_reset", port_count, 0);
    reset <= 1'b0;
    @(posedge clk);
    c0 = port_count;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("count_rate", 16'(port_count - c0), 10);
    @(posedge clk);
    // timed output words through all pin sharing configs
    for (int j = 0; j < 4; j++) begin
      dir_out <= 1'b1;
      oc <= oc_t[j];
      own <= own_t[j];
      link <= link_t[j];
      w = $random(seed);
      i_ext.seen.delete();
      i_ext.oe_seen.delete();
      c0 = 16'(port_count + 16'd20);
      cmd(CRP_OP_OUT, w, c0);
      n_xfer++;
      @(posedge clk);
      chk("ready_full", cmd_ready, 0);
      for (int i = 0; i < 200 && evt !== 1'b1; i++) @(posedge clk);
      chk("timestamp", timestamp, c0);
      for (int i = 0; i < 100 && (stb_out !== 1'b0 || i_ext.seen.size() < 16); i++)
        @(posedge clk);
      chk("slices", i_ext.seen.size(), 16);
      m = link_t[j] ? 4'h0 : ~own_t[j];
      for (int k = 0; k < 8 && i_ext.seen.size() == 16; k++) begin
        chk("slice", i_ext.seen[2*k] & m, w[4*k+:4] & m);
        if (!oc_t[j]) chk("oe", i_ext.oe_seen[2*k], m);
      end
      @(posedge clk);
    end
    // strobed input words, second with a pin owned elsewhere
    for (int j = 0; j < 2; j++) begin
      dir_out <= 1'b0;
      link <= 1'b0;
      stb_en <= 1'b1;
      own <= j ? 4'h8 : 4'h0;
      w = $random(seed);
      e = 0;
      for (int k = 0; k < 8; k++) e[4*k+:4] = w[4*k+:4] & (j ? 4'h7 : 4'hf);
      i_ext.send_word(w);
      n_xfer++;
      cmd(CRP_OP_IN, 0, 0);
      @(negedge clk);
      chk("rd_valid", rd_valid, 1);
      chk("rd_data", rd_data, e);
      @(posedge clk);
    end
    // start condition: first slice refused, word starts on the second
    for (int c = 0; c < 2; c++) begin
      own <= 4'h0;
      cond <= c ? CRP_COND_NEQ : CRP_COND_EQ;
      w = $random(seed);
      w2 = $random(seed);
      if (c) w[7:4] = ~w[3:0];
      else w[3:0] = ~w[7:4];
      cond_val <= c ? w[3:0] : w[7:4];
      e = {w2[3:0], w[31:4]};
      i_ext.send_word(w);
      i_ext.send_word(w2);
      n_xfer++;
      cmd(CRP_OP_IN, 0, 0);
      @(negedge clk);
      chk("cond_valid", rd_valid, 1);
      chk("cond_data", rd_data, e);
      @(posedge clk);
    end
    cond <= CRP_COND_NONE;
    // port clocked from the external clock through block 1, random divide
    cmd(CRP_OP_SETCLK, 1, 0);
    d = 8'($random(seed)) & 8'h03;
    cb_div[15:8] <= d;
    @(negedge clk);
    c0 = port_count;
    @(posedge clk);
    ext_run <= 1'b1;
    repeat (48) @(posedge clk);
    ext_run <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("ext_count", 16'(port_count - c0), 12 / (d + 1));
    @(posedge clk);
    repeat (4) @(posedge clk);
    chk("events", n_evt, n_xfer);
    final_report();
  end
endmodule
`default_nettype wire
